// ===== bench/flash_block_protection_tb.sv
/*
 * Self-checking bench for the flash block protection core: Wishbone register
 * traffic, debug writes, flash command launches and a second reset.
 * Assumes fbp_pkg and fbp_top are compiled first; no partner model is needed.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module flash_block_protection_tb
	import fbp_pkg::*;
;
	typedef struct packed {
		logic        chk;
		logic [31:0] val;
		logic [31:0] mask;
	} fbp_note_t;

	logic                    clock;
	logic                    rst_n;
	logic                    cyc, stb, we_i, ack, dbg_we, req, erase, done_i;
	logic [7:0]              adr_i, nv, dbg_d, fwdata;
	logic [3:0]              sel;
	logic [31:0]             dat_i, dout;
	logic [FBP_FLASH_AW-1:0] faddr;
	fbp_note_t               note_q[$];
	fbp_note_t               note;
	int                      err_total, n_compared, seed;
	logic [6:0]              blk[5] = '{7'h00, 7'h1F, 7'h20, 7'h21, 7'h7F};

	fbp_top u_dut (
		.CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we_i),
		.WB_ADR_I(adr_i), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dout), .WB_ACK_O(ack),
		.NV_PROT_BYTE(nv), .DBG_PROT_WE(dbg_we), .DBG_PROT_DATA(dbg_d), .FLASH_CMD_REQ(req),
		.FLASH_CMD_ERASE(erase), .FLASH_ADDR(faddr), .FLASH_WDATA(fwdata), .FLASH_DONE(done_i)
	);

	always #5 clock = ~clock;

	// Each answer retires the oldest note
	always @(posedge clock) begin
		if (ack === 1'b1) begin
			if (note_q.size() == 0) begin
				err_total++;
			end else begin
				note = note_q.pop_front();
				if (note.chk)
					`CHK(dout & note.mask, note.val)
			end
		end
	end

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic c,
		input logic [31:0] v, input logic [31:0] m);
		note_q.push_back('{c, v, m});
		@(posedge clock);
		cyc   <= 1'b1;
		stb   <= 1'b1;
		we_i  <= we;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
		wb(1'b0, a, 32'($random(seed)), 1'b1, v, m);
	endtask : rd

	task automatic dbg(input logic [7:0] d);
		@(posedge clock);
		dbg_we <= 1'b1;
		dbg_d  <= d;
		@(posedge clock);
		dbg_we <= 1'b0;
	endtask : dbg

	task automatic reset_dut();
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
	endtask : reset_dut

	task automatic launch(input logic [1:0] cmd, input logic [15:0] a, input logic ok);
		logic [7:0] d;
		d = 8'($random(seed));
		wr(FBP_OFF_CMD, {30'h0, cmd});
		wr(FBP_OFF_ADDR, {16'h0, a});
		wr(FBP_OFF_DATA, {24'h0, d});
		wr(FBP_OFF_STAT, 32'h80);
		#1;
		`CHK(req, ok)
		if (ok) begin
			`CHK({erase, faddr, fwdata}, {cmd == FBP_CMD_ERASE, a, d})
			rd(FBP_OFF_STAT, 32'h04, 32'hFF);
			@(posedge clock);
			done_i <= 1'b1;
			@(posedge clock);
			done_i <= 1'b0;
			#1;
			`CHK(req, 1'b0)
			rd(FBP_OFF_STAT, 32'hC0, 32'hFF);
		end else begin
			rd(FBP_OFF_STAT, (cmd == 2'h3) ? 32'h10 : 32'h20, 32'h30);
			wr(FBP_OFF_STAT, 32'h30);
			rd(FBP_OFF_STAT, 32'h00, 32'h30);
		end
	endtask : launch

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	initial begin
		#200000;
		err_total++;
		close_out();
	end

	initial begin
		seed = 52771;
		clock = 1'b0;
		rst_n = 1'b0;
		{cyc, stb, we_i, dbg_we, done_i} = 5'h00;
		{adr_i, dbg_d, dat_i} = 48'h0;
		sel = 4'hF;
		nv = 8'h50;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		rd(FBP_OFF_PROT, 32'h50, 32'hFFFFFFFF);
		wr(FBP_OFF_PROT, 32'h60);
		rd(FBP_OFF_PROT, 32'h50, 32'hFFFFFFFF);
		wr(FBP_OFF_PROT, 32'h41);
		rd(FBP_OFF_PROT, 32'h40, 32'hFFFFFFFF);
		wr(FBP_OFF_STAT, 32'h0B);
		rd(FBP_OFF_STAT, 32'h80, 32'hFF);
		rd(8'h1C, 32'h0, 32'hFFFFFFFF);
		// Boundary is block 0x20 (32) here
		foreach (blk[i])
			launch((32'($random(seed)) & 1) ? FBP_CMD_PROGRAM : FBP_CMD_ERASE,
				{blk[i], 9'($random(seed))}, blk[i] <= 7'h20);
		launch(2'h3, 16'h0000, 1'b0);
		dbg(8'h01);
		rd(FBP_OFF_PROT, 32'h01, 32'hFFFFFFFF);
		wr(FBP_OFF_PROT, 32'h00);
		rd(FBP_OFF_PROT, 32'h01, 32'hFFFFFFFF);
		launch(FBP_CMD_ERASE, 16'hFFFF, 1'b1);
		dbg(8'hFE);
		rd(FBP_OFF_PROT, 32'hFE, 32'hFFFFFFFF);
		launch(FBP_CMD_PROGRAM, 16'hFE00, 1'b1);
		nv <= 8'h03;
		reset_dut();
		rd(FBP_OFF_PROT, 32'h03, 32'hFFFFFFFF);
		close_out();
	end

endmodule : flash_block_protection_tb

`default_nettype wire

// ===== core/fbp_guard.sv
/*
 * Address guard: flags a flash address that lies in the protected region.
 * Assumes the boundary and disable come straight from the protection register.
 */
`timescale 1ns/100ps
`default_nettype none

module fbp_guard
	import fbp_pkg::*;
(
	// Protection setting
	input  wire logic [FBP_BND_W-1:0]    bound,
	input  wire logic                    prot_off,
	// Target address
	input  wire logic [FBP_FLASH_AW-1:0] addr,
	// Verdict
	output logic                         is_protected
);

	// Blocks above the boundary are locked unless protection is off
	assign is_protected = ~prot_off & (addr[FBP_FLASH_AW-1:FBP_BLOCK_LSB] > bound);

endmodule : fbp_guard

`default_nettype wire

// ===== core/fbp_pkg.sv
/*
 * Shared constants and types of the flash block protection core:
 * register offsets, field positions, reset values, commands and states.
 * Assumes a 32-bit classic Wishbone register bus and a 16-bit flash address.
 */
package fbp_pkg;

	// Register byte offsets
	localparam logic [7:0] FBP_OFF_PROT = 8'h00;
	localparam logic [7:0] FBP_OFF_STAT = 8'h04;
	localparam logic [7:0] FBP_OFF_CMD  = 8'h08;
	localparam logic [7:0] FBP_OFF_ADDR = 8'h0C;
	localparam logic [7:0] FBP_OFF_DATA = 8'h10;

	// Flash geometry
	localparam int FBP_FLASH_AW  = 16;
	localparam int FBP_BLOCK_LSB = 9;
	localparam int FBP_BND_W     = 7;

	// Protection register fields
	localparam int FBP_PROT_DIS_BIT = 0;
	localparam int FBP_PROT_BND_LSB = 1;
	localparam int FBP_PROT_BND_MSB = 7;

	// Status register fields
	localparam int FBP_ST_READY_BIT = 7;
	localparam int FBP_ST_DONE_BIT  = 6;
	localparam int FBP_ST_VIOL_BIT  = 5;
	localparam int FBP_ST_ERR_BIT   = 4;
	localparam int FBP_ST_BUSY_BIT  = 2;

	// Reset values
	localparam logic [7:0]  FBP_PROT_RST = 8'h00;
	localparam logic [1:0]  FBP_CMD_RST  = 2'h0;
	localparam logic [15:0] FBP_ADDR_RST = 16'h0000;
	localparam logic [7:0]  FBP_DATA_RST = 8'h00;

	// Command codes
	localparam logic [1:0] FBP_CMD_PROGRAM = 2'h1;
	localparam logic [1:0] FBP_CMD_ERASE   = 2'h2;

	typedef enum logic [2:0] {
		FBP_ST_LOAD = 3'h1,
		FBP_ST_IDLE = 3'h2,
		FBP_ST_BUSY = 3'h4
	} fbp_state_t;

endpackage : fbp_pkg

// ===== core/fbp_top.sv
/*
 * Flash block protection core: protection register, flash status register,
 * command launch with protection check, classic Wishbone slave.
 * Assumes the flash array, its nonvolatile byte and the debug path share CLOCK.
 */
//
// Contract
// - Protection register loads from the nonvolatile protection byte at reset.
// - Protection register reads back boundary and disable at any time.
// - With protection enabled, only a smaller or equal boundary is accepted.
// - With protection disabled, software writes leave protection unchanged.
// - Bits 7:1 hold the boundary; blocks above it are protected.
// - Program or erase aimed at a protected location is refused.
// - Bit 0 disables protection; when set no block is protected.
// - Debug path rewrites protection bits without any restriction; code ignores it in the load state.
// - Status bits 3, 1, 0 read zero and ignore writes.
// - Other five status bits are readable; writes act per bit.
`timescale 1ns/100ps
`default_nettype none

module fbp_top
	import fbp_pkg::*;
(
	// Clock and reset
	input  wire logic                    CLOCK,
	input  wire logic                    RST_N,
	// Wishbone slave
	input  wire logic                    WB_CYC_I,
	input  wire logic                    WB_STB_I,
	input  wire logic                    WB_WE_I,
	input  wire logic [7:0]              WB_ADR_I,
	input  wire logic [3:0]              WB_SEL_I,
	input  wire logic [31:0]             WB_DAT_I,
	output logic      [31:0]             WB_DAT_O,
	output logic                         WB_ACK_O,
	// Nonvolatile protection byte
	input  wire logic [7:0]              NV_PROT_BYTE,
	// Background debug path
	input  wire logic                    DBG_PROT_WE,
	input  wire logic [7:0]              DBG_PROT_DATA,
	// Flash array command port
	output logic                         FLASH_CMD_REQ,
	output logic                         FLASH_CMD_ERASE,
	output logic [FBP_FLASH_AW-1:0]      FLASH_ADDR,
	output logic [7:0]                   FLASH_WDATA,
	input  wire logic                    FLASH_DONE
);

	fbp_state_t                state_q;
	fbp_state_t                state_d;
	logic [7:0]                flash_protection_control_q;
	logic [1:0]                cmd_q;
	logic [FBP_FLASH_AW-1:0]   addr_q;
	logic [7:0]                data_q;
	logic                      run_erase_q;
	logic                      done_q;
	logic                      viol_q;
	logic                      err_q;
	logic                      ack_q;
	logic [31:0]               dat_q;
	logic [7:0]                flash_status;
	logic                      wb_go;
	logic                      wb_take;
	logic                      wr_lane0;
	logic                      sw_prot_wr;
	logic                      launch;
	logic                      cmd_legal;
	logic                      target_locked;
	logic                      start;
	logic                      viol_set;
	logic                      err_set;
	logic                      viol_clr;
	logic                      err_clr;
	logic                      raise_ok;
	logic [FBP_BND_W-1:0]      bound;
	logic                      prot_off;

	assign bound    = flash_protection_control_q[FBP_PROT_BND_MSB:FBP_PROT_BND_LSB];
	assign prot_off = flash_protection_control_q[FBP_PROT_DIS_BIT];

	// Bus decode; read sampled when taken, write lands on the edge the master sees ack
	assign wb_go    = WB_CYC_I & WB_STB_I & ~ack_q;
	assign wb_take  = WB_CYC_I & WB_STB_I & ack_q & WB_WE_I;
	assign wr_lane0 = wb_take & WB_SEL_I[0];
	assign sw_prot_wr = wr_lane0 & (WB_ADR_I == FBP_OFF_PROT) & (state_q != FBP_ST_LOAD);

	// Launch: writing one to the ready bit while idle
	assign launch = wr_lane0 & (WB_ADR_I == FBP_OFF_STAT) & WB_DAT_I[FBP_ST_READY_BIT]
		& (state_q == FBP_ST_IDLE);
	assign cmd_legal = (cmd_q == FBP_CMD_PROGRAM) | (cmd_q == FBP_CMD_ERASE);
	assign start     = launch & cmd_legal & ~target_locked;
	assign viol_set  = launch & cmd_legal & target_locked;
	assign err_set   = launch & ~cmd_legal;
	assign viol_clr  = wr_lane0 & (WB_ADR_I == FBP_OFF_STAT) & WB_DAT_I[FBP_ST_VIOL_BIT];
	assign err_clr   = wr_lane0 & (WB_ADR_I == FBP_OFF_STAT) & WB_DAT_I[FBP_ST_ERR_BIT];

	// Only equal or smaller boundary while protection is on
	assign raise_ok = ~prot_off & (WB_DAT_I[FBP_PROT_BND_MSB:FBP_PROT_BND_LSB] <= bound);

	fbp_guard u_guard (
		.bound        (bound),
		.prot_off     (prot_off),
		.addr         (addr_q),
		.is_protected (target_locked)
	);

	// Sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			FBP_ST_LOAD: begin
				state_d = FBP_ST_IDLE;
			end
			FBP_ST_IDLE: begin
				if (start) begin
					state_d = FBP_ST_BUSY;
				end
			end
			FBP_ST_BUSY: begin
				if (FLASH_DONE) begin
					state_d = FBP_ST_IDLE;
				end
			end
			default: begin
				state_d = FBP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= FBP_ST_LOAD;
		end else begin
			state_q <= state_d;
		end
	end

	// Protection register; locked-down value until the nonvolatile byte is taken
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			flash_protection_control_q <= FBP_PROT_RST;
		end else if (state_q == FBP_ST_LOAD) begin
			flash_protection_control_q <= NV_PROT_BYTE;
		end else if (DBG_PROT_WE) begin
			flash_protection_control_q <= DBG_PROT_DATA;
		end else if (sw_prot_wr && raise_ok) begin
			flash_protection_control_q <= {WB_DAT_I[FBP_PROT_BND_MSB:FBP_PROT_BND_LSB], 1'b0};
		end
	end

	// Command, address and data; frozen while a command runs
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_q  <= FBP_CMD_RST;
			addr_q <= FBP_ADDR_RST;
			data_q <= FBP_DATA_RST;
		end else if (state_q == FBP_ST_IDLE) begin
			if (wr_lane0 && WB_ADR_I == FBP_OFF_CMD) begin
				cmd_q <= WB_DAT_I[1:0];
			end
			if (wb_take && WB_ADR_I == FBP_OFF_ADDR) begin
				if (WB_SEL_I[0]) begin
					addr_q[7:0] <= WB_DAT_I[7:0];
				end
				if (WB_SEL_I[1]) begin
					addr_q[15:8] <= WB_DAT_I[15:8];
				end
			end
			if (wr_lane0 && WB_ADR_I == FBP_OFF_DATA) begin
				data_q <= WB_DAT_I[7:0];
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			run_erase_q <= 1'b0;
		end else if (start) begin
			run_erase_q <= (cmd_q == FBP_CMD_ERASE);
		end
	end

	// Status flags; set wins over clear
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			done_q <= 1'b0;
		end else if (state_q == FBP_ST_BUSY && FLASH_DONE) begin
			done_q <= 1'b1;
		end else if (start) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			viol_q <= 1'b0;
		end else if (viol_set) begin
			viol_q <= 1'b1;
		end else if (viol_clr) begin
			viol_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			err_q <= 1'b0;
		end else if (err_set) begin
			err_q <= 1'b1;
		end else if (err_clr) begin
			err_q <= 1'b0;
		end
	end

	// Status view; bits 3, 1, 0 tied low
	always_comb begin
		flash_status = 8'h00;
		flash_status[FBP_ST_READY_BIT] = (state_q == FBP_ST_IDLE);
		flash_status[FBP_ST_DONE_BIT]  = done_q;
		flash_status[FBP_ST_VIOL_BIT]  = viol_q;
		flash_status[FBP_ST_ERR_BIT]   = err_q;
		flash_status[FBP_ST_BUSY_BIT]  = (state_q == FBP_ST_BUSY);
	end

	// Bus answer; unmapped offsets read zero and writes there are dropped
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_go;
			if (wb_go) begin
				unique case (WB_ADR_I)
					FBP_OFF_PROT: dat_q <= {24'h00_0000, flash_protection_control_q};
					FBP_OFF_STAT: dat_q <= {24'h00_0000, flash_status};
					FBP_OFF_CMD:  dat_q <= {30'h0000_0000, cmd_q};
					FBP_OFF_ADDR: dat_q <= {16'h0000, addr_q};
					FBP_OFF_DATA: dat_q <= {24'h00_0000, data_q};
					default:      dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign WB_ACK_O        = ack_q;
	assign WB_DAT_O        = dat_q;
	assign FLASH_CMD_REQ   = (state_q == FBP_ST_BUSY);
	assign FLASH_CMD_ERASE = run_erase_q;
	assign FLASH_ADDR      = addr_q;
	assign FLASH_WDATA     = data_q;

	// Checks
	nv_load_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(state_q == FBP_ST_LOAD) |=> (flash_protection_control_q == $past(NV_PROT_BYTE)))
		else $error("protection register not loaded from nonvolatile byte");

	prot_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == FBP_OFF_PROT)
		|-> (WB_DAT_O == {24'h00_0000, $past(flash_protection_control_q)}))
		else $error("protection register read returned wrong value");

	bound_shrink_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		$past(sw_prot_wr && !DBG_PROT_WE && !prot_off)
		|-> (bound <= $past(bound)) && !prot_off)
		else $error("protection reduced by software write");

	no_raise_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(sw_prot_wr && !DBG_PROT_WE && !prot_off
		&& WB_DAT_I[FBP_PROT_BND_MSB:FBP_PROT_BND_LSB] > bound)
		|=> $stable(flash_protection_control_q))
		else $error("larger boundary accepted while protected");

	dis_locked_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(sw_prot_wr && !DBG_PROT_WE && prot_off) |=> $stable(flash_protection_control_q))
		else $error("software write changed disabled protection");

	refuse_cmd_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(launch && target_locked) |=> !FLASH_CMD_REQ ##0 (viol_q || err_q))
		else $error("command to protected location not refused");

	launch_go_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		start |=> FLASH_CMD_REQ && !flash_status[FBP_ST_READY_BIT] && (FLASH_ADDR == $past(addr_q)))
		else $error("accepted command not issued to flash");

	dis_free_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		prot_off |-> !target_locked)
		else $error("location protected while protection disabled");

	dbg_write_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(DBG_PROT_WE && state_q != FBP_ST_LOAD) |=> (flash_protection_control_q == $past(DBG_PROT_DATA)))
		else $error("debug write to protection register lost");

	stat_zero_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == FBP_OFF_STAT)
		|-> (WB_DAT_O[31:8] == 24'h00_0000) && !WB_DAT_O[3] && !WB_DAT_O[1] && !WB_DAT_O[0])
		else $error("reserved status bits not zero");

	done_flag_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(FLASH_CMD_REQ && FLASH_DONE) |=> done_q && !FLASH_CMD_REQ && (state_q == FBP_ST_IDLE))
		else $error("command completion not flagged");

endmodule : fbp_top

`default_nettype wire
